//--- logic/sro_pkg.sv
// package of constants for the serial-in latched power output shifter
`default_nettype none
package sro_pkg;
  localparam int SRO_WIDTH = 8;
  localparam int SRO_FIFO_DEPTH = 8;
  localparam logic [7:0] SRO_CHAIN_RESET = 8'h00;
  localparam logic [7:0] SRO_HOLD_RESET = 8'h00;
  localparam logic [1:0] SRO_SYNC_RESET = 2'h0;
  localparam logic [1:0] SRO_SYNC_IDLE_HIGH = 2'h3;
endpackage : sro_pkg
`default_nettype wire

//--- logic/sro_fifo.sv
// small fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module sro_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      case ({push, pop})
        2'b10: count <= count + 1'b1;
        2'b01: count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end
endmodule : sro_fifo
`default_nettype wire

//--- logic/sro_top.sv
// serial-in latched power output shifter top level
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - an eight-stage chain fed from serial_in is readable at its end and in parallel via a holding register.
// - the chain is stepped by shift_clk and the holding register by latch_clk, independently.
// - clear_n low clears chain and holding register at once, regardless of either clock.
// - each rising shift_clk edge shifts the chain one stage and takes serial_in into stage zero.
// - each rising latch_clk edge copies all eight chain stages into the holding register.
// - cascade_out shows the last chain stage and changes only on a rising shift_clk edge or when clear_n goes low.
// - with both clocks tied, the holding register takes the chain value from before the edge.
// - with out_en_n low each power output follows its holding register bit.
// - with out_en_n high all power outputs are off and high impedance.
// - out_en_n never alters chain or holding register.
// - eight open-drain outputs, one per holding bit, each a low-side switch.
module sro_top
  import sro_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // host pins
  input wire logic serial_in,
  input wire logic shift_clk,
  input wire logic latch_clk,
  input wire logic clear_n,
  input wire logic out_en_n,
  // cascade
  output logic cascade_out,
  // open-drain power outputs: drive low when enabled
  output logic [SRO_WIDTH-1:0] power_out,
  output logic [SRO_WIDTH-1:0] power_out_oe
);
  logic [1:0] sync_data;
  logic [1:0] sync_sclk;
  logic [1:0] sync_lclk;
  logic [1:0] sync_clr;
  logic [1:0] sync_oe;
  logic sclk_prev;
  logic lclk_prev;
  logic shift_edge;
  logic latch_edge;
  logic clear_now;
  logic [SRO_WIDTH-1:0] chain;
  logic [SRO_WIDTH-1:0] next_chain;
  logic [SRO_WIDTH-1:0] hold;
  logic fifo_ready;
  logic fifo_valid;
  logic [SRO_WIDTH-1:0] fifo_data;
  logic [SRO_WIDTH-1:0] next_power_out_oe;

  // rising edge of a synchronised pin
  function automatic logic rise_of(input logic cur_level, input logic old_level);
    rise_of = cur_level && !old_level;
  endfunction : rise_of

  // two-stage synchronisers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sync_data <= SRO_SYNC_RESET;
      sync_sclk <= SRO_SYNC_RESET;
      sync_lclk <= SRO_SYNC_RESET;
      sync_clr <= SRO_SYNC_IDLE_HIGH;
      sync_oe <= SRO_SYNC_IDLE_HIGH;
    end
    else
    begin
      sync_data <= {sync_data[0], serial_in};
      sync_sclk <= {sync_sclk[0], shift_clk};
      sync_lclk <= {sync_lclk[0], latch_clk};
      sync_clr <= {sync_clr[0], clear_n};
      sync_oe <= {sync_oe[0], out_en_n};
    end
  end

  // edge finders
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sclk_prev <= 1'b0;
      lclk_prev <= 1'b0;
    end
    else
    begin
      sclk_prev <= sync_sclk[1];
      lclk_prev <= sync_lclk[1];
    end
  end

  assign shift_edge = rise_of(sync_sclk[1], sclk_prev);
  assign latch_edge = rise_of(sync_lclk[1], lclk_prev);
  assign clear_now = !sync_clr[1];
  assign next_chain = {chain[SRO_WIDTH-2:0], sync_data[1]};

  // shift chain
  always_ff @(posedge clk)
  begin
    if (reset || clear_now)
    begin
      chain <= SRO_CHAIN_RESET;
    end
    else if (shift_edge)
    begin
      chain <= next_chain;
    end
  end

  // chain snapshots queue toward the holding register
  sro_fifo #(
    .WIDTH(SRO_WIDTH),
    .DEPTH(SRO_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset || clear_now),
    .in_valid(latch_edge),
    .in_ready(fifo_ready),
    .in_data(chain),
    .out_valid(fifo_valid),
    .out_ready(1'b1),
    .out_data(fifo_data)
  );

  // holding register
  always_ff @(posedge clk)
  begin
    if (reset || clear_now)
    begin
      hold <= SRO_HOLD_RESET;
    end
    else if (fifo_valid)
    begin
      hold <= fifo_data;
    end
  end

  assign cascade_out = chain[SRO_WIDTH-1];
  assign power_out = '0;
  assign next_power_out_oe = sync_oe[1] ? '0 : hold;

  // gate drive register, a high bit turns its switch on
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      power_out_oe <= SRO_HOLD_RESET;
    end
    else
    begin
      power_out_oe <= next_power_out_oe;
    end
  end

  // clear checks
  chk_clear_both: assert property (@(posedge clk) disable iff (reset)
    clear_now |=> (chain == '0 && hold == '0))
    else $error("clear did not empty registers");

  chk_clear_outputs: assert property (@(posedge clk) disable iff (reset)
    clear_now |-> ##2 power_out_oe == '0)
    else $error("clear left outputs on");

  chk_cascade_clear: assert property (@(posedge clk) disable iff (reset)
    clear_now |=> cascade_out == 1'b0)
    else $error("clear left cascade high");

  // shift path checks
  sequence s_sclk_pin_rise;
    $rose(shift_clk);
  endsequence

  chk_shift_seen: assert property (@(posedge clk) disable iff (reset)
    s_sclk_pin_rise |-> ##[1:3] shift_edge)
    else $error("shift clock edge missed");

  chk_shift_step: assert property (@(posedge clk) disable iff (reset)
    (shift_edge && !clear_now) |=> chain == {$past(chain[6:0]), $past(sync_data[1])})
    else $error("shift step wrong");

  chk_chain_quiet: assert property (@(posedge clk) disable iff (reset)
    (!$past(shift_edge) && !$past(clear_now) && !$past(reset)) |-> $stable(chain))
    else $error("chain changed without shift edge");

  chk_cascade_stable: assert property (@(posedge clk) disable iff (reset)
    (!$past(shift_edge) && !$past(clear_now) && !$past(reset)) |-> $stable(cascade_out))
    else $error("cascade changed without shift edge");

  // latch path checks
  sequence s_lclk_pin_rise;
    $rose(latch_clk);
  endsequence

  chk_latch_seen: assert property (@(posedge clk) disable iff (reset)
    s_lclk_pin_rise |-> ##[1:3] latch_edge)
    else $error("latch clock edge missed");

  sequence s_latch_req;
    latch_edge && !clear_now;
  endsequence

  chk_latch_copy: assert property (@(posedge clk) disable iff (reset)
    (s_latch_req ##1 !clear_now [*2]) |-> hold == $past(chain, 2))
    else $error("latch copy wrong");

  chk_fifo_room: assert property (@(posedge clk) disable iff (reset)
    latch_edge |-> fifo_ready)
    else $error("latch snapshot dropped");

  chk_hold_source: assert property (@(posedge clk) disable iff (reset)
    (!$past(fifo_valid) && !$past(clear_now) && !$past(reset)) |-> $stable(hold))
    else $error("hold changed without latch");

  chk_hold_quiet: assert property (@(posedge clk) disable iff (reset)
    (!fifo_valid && !clear_now && $changed(sync_oe[1])) |=> $stable(hold))
    else $error("enable changed hold");

  // output checks
  chk_out_off: assert property (@(posedge clk) disable iff (reset)
    sync_oe[1] |=> power_out_oe == '0)
    else $error("outputs on while disabled");

  chk_out_follow: assert property (@(posedge clk) disable iff (reset)
    !sync_oe[1] |=> power_out_oe == $past(hold))
    else $error("outputs do not follow hold");

  chk_drive_low: assert property (@(posedge clk) disable iff (reset)
    power_out == '0)
    else $error("open drain drove high");
endmodule : sro_top
`default_nettype wire

//--- bench/sro_host_model.sv
// host controller model driving the serial pins
`timescale 1ns/100ps
`default_nettype none
module sro_host_model (
  // system clock
  input wire logic clk,
  // host pins
  output logic serial_in,
  output logic shift_clk,
  output logic latch_clk
);
  initial
  begin
    serial_in = 1'b0;
    shift_clk = 1'b0;
    latch_clk = 1'b0;
  end
  // one 800 ns clock period, four cycles low and four high, data inverted after the fall
  task step(input logic b, input logic s, input logic l);
    @(posedge clk) serial_in <= b;
    repeat (2) @(posedge clk);
    shift_clk <= s;
    latch_clk <= l;
    repeat (4) @(posedge clk);
    shift_clk <= 1'b0;
    latch_clk <= 1'b0;
    serial_in <= ~b;
    repeat (2) @(negedge clk);
  endtask : step
endmodule : sro_host_model
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the power output shifter
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import sro_pkg::*;
  logic clk, reset, clear_n, out_en_n, serial_in, shift_clk, latch_clk, cascade_out;
  logic [SRO_WIDTH-1:0] power_out, power_out_oe;
  logic [7:0] m_chain, m_hold, d;
  logic [31:0] lfsr;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  sro_host_model host (.clk(clk), .serial_in(serial_in), .shift_clk(shift_clk), .latch_clk(latch_clk));
  sro_top uut (.clk(clk), .reset(reset), .serial_in(serial_in), .shift_clk(shift_clk),
    .latch_clk(latch_clk), .clear_n(clear_n), .out_en_n(out_en_n), .cascade_out(cascade_out),
    .power_out(power_out), .power_out_oe(power_out_oe));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function logic [31:0] next_rand(input logic [31:0] v);
    next_rand = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : next_rand
  task final_report;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors = errors + 1;
      $display("BAD %0t timeout", $time);
      final_report();
    end
  end
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task cmp_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t bit got %b want %b", $time, got, exp);
    end
  endtask : cmp_bit
  // one pin pulse, then model update: latch sees the chain before the shift
  task sh(input logic b, input logic s, input logic l);
    host.step(b, s, l);
    if (l) m_hold = m_chain;
    if (s) m_chain = {m_chain[6:0], b};
    cmp_bit(cascade_out, m_chain[7]);
    cmp(power_out_oe, out_en_n ? 8'h00 : m_hold);
  endtask : sh
  task send(input logic [7:0] v, input logic t);
    for (int i = 7; i >= 0; i--) sh(v[i], 1'b1, t);
  endtask : send
  task oe(input logic v);
    @(posedge clk) out_en_n <= v;
    repeat (5) @(negedge clk);
  endtask : oe
  initial
  begin
    reset = 1'b1;
    clear_n = 1'b1;
    out_en_n = 1'b0;
    m_chain = 8'h00;
    m_hold = 8'h00;
    lfsr = 32'h0A35;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(negedge clk);
    cmp(power_out_oe, SRO_HOLD_RESET);
    for (int k = 0; k < 4; k++)
    begin
      lfsr = next_rand(lfsr);
      send(lfsr[7:0], 1'b0);
      sh(1'b0, 1'b0, 1'b1);
      cmp(power_out, 8'h00);
    end
    $display("test load done");
    d = m_hold;
    oe(1'b1);
    cmp(power_out_oe, 8'h00);
    lfsr = next_rand(lfsr);
    send(lfsr[7:0], 1'b0);
    oe(1'b0);
    cmp(power_out_oe, d);
    $display("test enable done");
    lfsr = next_rand(lfsr);
    send(lfsr[7:0], 1'b1);
    $display("test tied done");
    @(posedge clk) clear_n <= 1'b0;
    repeat (6) @(negedge clk);
    m_chain = 8'h00;
    m_hold = 8'h00;
    cmp(power_out_oe, 8'h00);
    cmp_bit(cascade_out, 1'b0);
    @(posedge clk) clear_n <= 1'b1;
    sh(1'b1, 1'b1, 1'b0);
    sh(1'b0, 1'b0, 1'b1);
    $display("test clear done");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
